/* File: rtl/pppf_pkg.sv */
// Package for the parallel programming port flow block
package pppf_pkg;
	// Timing
	localparam int unsigned CLK_HZ          = 40_000_000;
	localparam int unsigned LATCH_WIN_US    = 10;
	localparam int unsigned LATCH_WIN_CYC   = (LATCH_WIN_US * (CLK_HZ / 1_000_000));
	localparam int unsigned PAGE_PROG_US    = 4000;
	localparam int unsigned PAGE_PROG_CYC   = (PAGE_PROG_US * (CLK_HZ / 1_000_000));
	localparam int unsigned ERASE_STEP_US   = 4000;
	localparam int unsigned ERASE_STEP_CYC  = (ERASE_STEP_US * (CLK_HZ / 1_000_000));
	// Action select coding
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;
	// Command bytes
	localparam logic [7:0] CMD_NOP      = 8'h00;
	localparam logic [7:0] CMD_ERASE    = 8'h80;
	localparam logic [7:0] CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] CMD_WR_EEP   = 8'h11;
	// Geometry
	localparam int unsigned FL_WORDS  = 32;
	localparam int unsigned FL_WBITS  = 5;
	localparam int unsigned FL_PAGES  = 128;
	localparam int unsigned EE_BYTES  = 4;
	localparam int unsigned EE_BBITS  = 2;
	localparam logic [7:0]  ERASED    = 8'hFF;
	localparam logic [3:0]  ENTRY_PAT = 4'h0;
	// Memory write request toward the arrays
	typedef struct packed {
		logic        flash;
		logic        eeprom;
		logic [6:0]  page;
		logic [15:0] addr;
	} pppf_req_t;
endpackage

/* File: rtl/pppf_core.sv */
// Parallel programming port: mode entry, loads, page buffers, erase and page write
// Function
// - Entry pattern held ten microseconds after high voltage; device latches it.
// - Programming mode ends on power down or reset back to 0 V.
// - Command and address stay loaded across operations.
// - Erase clears flash, eeprom and locks; fuses kept; preserve fuse keeps eeprom.
// - Lock bits cleared only after program memory fully erased.
// - Action select 10 command, 00 address, 01 data; byte select low/high.
// - Each load strobe pulse while not busy captures data bus into selected target.
// - Decode 80 erase, 10 write flash, 11 write eeprom.
// - Loading the no-operation command resets internal write signals.
// - Write strobe low pulse starts operation; status low until done.
// - Page latch pulse with byte select high stores data at low address word.
// - Low address bits pick word in page, upper bits pick the page.
// - Flash page is 32 words, five low bits word, 128 pages.
// - Eeprom page is four bytes, two low bits select byte.
`timescale 1ns/1ps
module pppf_core (
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	// Programming mode request (high voltage on reset pin)
	input  wire logic                  hv_present,
	input  wire logic                  eeprom_preserve_fuse,
	// Control pins
	input  wire logic                  action_select_hi,
	input  wire logic                  action_select_lo,
	input  wire logic                  byte_select_low,
	input  wire logic                  byte_select_second,
	input  wire logic                  page_latch_strobe,
	input  wire logic                  load_strobe,
	input  wire logic                  write_strobe_n,
	input  wire logic [7:0]            data_in,
	// Status
	output logic                       ready_busy_status,
	output logic                       prog_mode,
	output logic                       lock_bits_clear,
	// Memory write port
	output pppf_pkg::pppf_req_t        mem_req,
	output logic                       mem_we,
	output logic [15:0]                mem_wdata,
	output logic [4:0]                 mem_word
);
	import pppf_pkg::*;

	typedef enum {S_IDLE, S_FLASH, S_ERASE_FL, S_ERASE_EE, S_ERASE_LK, S_EEP, S_WAIT} pppf_st_t;

	// Edge detect on a synchronised strobe pair
	function automatic logic rise(input logic cur, input logic prev);
		rise = cur & ~prev;
	endfunction

	// Page number of an address: flash pages are 32 words, eeprom pages 4 bytes
	function automatic logic [6:0] page_of(input logic [15:0] a, input logic eep);
		page_of = eep ? a[EE_BBITS +: 7] : a[FL_WBITS +: 7];
	endfunction

	//==========================================================
	// Strobe synchronisers
	//==========================================================
	logic [2:0] ld_sync_ff;
	logic [2:0] pl_sync_ff;
	logic [2:0] wr_sync_ff;
	logic [2:0] hv_sync_ff;
	logic       ld_edge;
	logic       pl_edge;
	logic       wr_edge;

	// Three stages: the first only feeds the second, edge taken from the last two
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ld_sync_ff <= 3'h0;
			pl_sync_ff <= 3'h0;
			wr_sync_ff <= 3'h0;  // Idle level of the inverted strobe, no false edge
			hv_sync_ff <= 3'h0;
		end else begin
			ld_sync_ff <= {ld_sync_ff[1:0], load_strobe};
			pl_sync_ff <= {pl_sync_ff[1:0], page_latch_strobe};
			wr_sync_ff <= {wr_sync_ff[1:0], ~write_strobe_n};
			hv_sync_ff <= {hv_sync_ff[1:0], hv_present};
		end
	end
	assign ld_edge = rise(ld_sync_ff[1], ld_sync_ff[2]);
	assign pl_edge = rise(pl_sync_ff[1], pl_sync_ff[2]);
	assign wr_edge = rise(wr_sync_ff[1], wr_sync_ff[2]);

	//==========================================================
	// Mode entry
	//==========================================================
	logic [15:0] win_cnt_ff;
	logic        mode_ff;
	logic        pat_ok_ff;
	logic        hv_on;
	logic [3:0]  entry_pat;

	assign hv_on     = hv_sync_ff[1];
	assign entry_pat = {page_latch_strobe, action_select_hi, action_select_lo, byte_select_second};

	// Pattern must hold through the whole window before mode is granted
	// A wrong pattern blocks entry until the voltage is removed and reapplied
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			win_cnt_ff <= 16'h0000;
			pat_ok_ff  <= 1'b0;
			mode_ff    <= 1'b0;
		end else if (!hv_on) begin
			win_cnt_ff <= 16'h0000;
			pat_ok_ff  <= 1'b1;
			mode_ff    <= 1'b0;
		end else if (!mode_ff) begin
			if (entry_pat != ENTRY_PAT) begin
				pat_ok_ff <= 1'b0;
			end
			if (win_cnt_ff == 16'(LATCH_WIN_CYC - 1)) begin
				mode_ff <= pat_ok_ff && (entry_pat == ENTRY_PAT);
			end else begin
				win_cnt_ff <= win_cnt_ff + 16'h0001;
			end
		end
	end

	//==========================================================
	// Command, address and data loads
	//==========================================================
	logic [7:0]  cmd_ff;
	logic [15:0] addr_ff;
	logic [15:0] data_ff;
	logic [1:0]  act;
	logic        busy;

	assign act = {action_select_hi, action_select_lo};

	// Held until overwritten, so one command serves many locations
	// Loads while busy are dropped, so a no-op cannot cut a running page write
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cmd_ff  <= CMD_NOP;
			addr_ff <= 16'h0000;
			data_ff <= 16'h0000;
		end else if (!mode_ff) begin
			cmd_ff  <= CMD_NOP;
		end else if (ld_edge && !busy) begin
			case (act)
				ACT_CMD:  cmd_ff <= data_in;
				ACT_ADDR: begin
					if (byte_select_low) addr_ff[15:8] <= data_in;
					else                 addr_ff[7:0]  <= data_in;
				end
				ACT_DATA: begin
					if (byte_select_low) data_ff[15:8] <= data_in;
					else                 data_ff[7:0]  <= data_in;
				end
				default: ;
			endcase
		end
	end

	//==========================================================
	// Page buffers
	//==========================================================
	logic [15:0] fl_buf [FL_WORDS];
	logic [7:0]  ee_buf [EE_BYTES];
	logic        is_flash;
	logic        is_eep;

	assign is_flash = (cmd_ff == CMD_WR_FLASH);
	assign is_eep   = (cmd_ff == CMD_WR_EEP);

	// Flash buffer is not preset: words not latched since the last page write
	// go to the array with their old contents
	always_ff @(posedge mclk) begin
		if (mode_ff && pl_edge && !busy) begin
			if (is_flash && byte_select_low) begin
				fl_buf[addr_ff[FL_WBITS-1:0]] <= data_ff;
			end else if (is_eep) begin
				ee_buf[addr_ff[EE_BBITS-1:0]] <= data_ff[7:0];
			end
		end
	end

	//==========================================================
	// Operation sequencer
	//==========================================================
	pppf_st_t    st_ff;
	logic [23:0] tmr_ff;
	logic [5:0]  idx_ff;
	logic        start;
	logic        known_cmd;
	logic        go;

	assign busy  = (st_ff != S_IDLE);
	assign start = mode_ff && wr_edge && !busy;

	// Only a decoded command pulls the status low; others leave it ready
	assign known_cmd = (cmd_ff == CMD_ERASE) || is_flash || is_eep;
	assign go        = start && known_cmd;

	// Erase runs flash, then eeprom unless the preserve fuse is set, then locks so locks fall last
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_ff  <= S_IDLE;
			tmr_ff <= 24'h000000;
			idx_ff <= 6'h00;
		end else if (!mode_ff) begin
			st_ff  <= S_IDLE;
		end else begin
			case (st_ff)
				S_IDLE: begin
					idx_ff <= 6'h00;
					tmr_ff <= 24'h000000;
					// An undecoded command is taken by the strobe but starts nothing
					if (start && cmd_ff == CMD_ERASE) st_ff <= S_ERASE_FL;
					else if (start && is_flash)       st_ff <= S_FLASH;
					else if (start && is_eep)         st_ff <= S_EEP;
				end
				S_FLASH: begin
					idx_ff <= idx_ff + 6'h01;
					if (idx_ff == 6'(FL_WORDS - 1)) st_ff <= S_WAIT;
				end
				S_EEP: begin
					idx_ff <= idx_ff + 6'h01;
					if (idx_ff == 6'(EE_BYTES - 1)) st_ff <= S_WAIT;
				end
				S_ERASE_FL: begin
					tmr_ff <= tmr_ff + 24'h000001;
					if (tmr_ff == 24'(ERASE_STEP_CYC - 1)) begin
						tmr_ff <= 24'h000000;
						st_ff  <= eeprom_preserve_fuse ? S_ERASE_LK : S_ERASE_EE;
					end
				end
				S_ERASE_EE: begin
					tmr_ff <= tmr_ff + 24'h000001;
					if (tmr_ff == 24'(ERASE_STEP_CYC - 1)) begin
						tmr_ff <= 24'h000000;
						st_ff  <= S_ERASE_LK;
					end
				end
				S_ERASE_LK: st_ff <= S_IDLE;
				// Fixed page write time: the array gives no done signal
				S_WAIT: begin
					tmr_ff <= tmr_ff + 24'h000001;
					if (tmr_ff == 24'(PAGE_PROG_CYC - 1)) st_ff <= S_IDLE;
				end
				default: st_ff <= S_IDLE;
			endcase
		end
	end

	//==========================================================
	// Outputs
	//==========================================================
	// Registered so the array sees clean write cycles
	// Status low only for a command that will run, from the write edge on
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ready_busy_status <= 1'b1;
			prog_mode         <= 1'b0;
			lock_bits_clear   <= 1'b0;
			mem_req           <= '0;
			mem_we            <= 1'b0;
			mem_wdata         <= 16'h0000;
			mem_word          <= 5'h00;
		end else begin
			ready_busy_status <= !(busy || go);
			prog_mode         <= mode_ff;
			lock_bits_clear   <= (st_ff == S_ERASE_LK);
			mem_we            <= 1'b0;
			mem_req.flash     <= 1'b0;
			mem_req.eeprom    <= 1'b0;
			mem_req.page      <= page_of(addr_ff, is_eep);
			mem_req.addr      <= addr_ff;
			mem_word          <= idx_ff[4:0];
			// Loads are dropped while busy, so the command gating these writes cannot change mid-write
			if (is_flash && st_ff == S_FLASH) begin
				mem_we        <= 1'b1;
				mem_req.flash <= 1'b1;
				mem_wdata     <= fl_buf[idx_ff[4:0]];
			end else if (is_eep && st_ff == S_EEP) begin
				mem_we         <= 1'b1;
				mem_req.eeprom <= 1'b1;
				mem_wdata      <= {8'h00, ee_buf[idx_ff[1:0]]};
			end else if (st_ff == S_ERASE_FL) begin
				mem_req.flash <= 1'b1;
				mem_we        <= 1'b1;
				mem_wdata     <= {ERASED, ERASED};
			end else if (st_ff == S_ERASE_EE) begin
				mem_req.eeprom <= 1'b1;
				mem_we         <= 1'b1;
				mem_wdata      <= {ERASED, ERASED};
			end
		end
	end
endmodule

/* File: sim/pppf_chk.sv */
// Checker for the programming port outputs
`timescale 1ns/1ps
module pppf_chk (
	// Clock and reset
	input wire logic                mclk,
	input wire logic                resetn,
	// Pins and status
	input wire logic                hv_present,
	input wire logic                write_strobe_n,
	input wire logic                ready_busy_status,
	input wire logic                prog_mode,
	input wire logic                lock_bits_clear,
	// Memory port
	input wire pppf_pkg::pppf_req_t mem_req,
	input wire logic                mem_we
);
	import pppf_pkg::*;
	logic [3:0] wr_age_ff;
	logic       fl_seen_ff;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// Cycles since write strobe low, saturates so old pulses never excuse a busy
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) wr_age_ff <= 4'hF;
		else if (!write_strobe_n) wr_age_ff <= 4'h0;
		else if (wr_age_ff != 4'hF) wr_age_ff <= wr_age_ff + 4'h1;
	end
	// Flash write cycle (erase or page write) seen since the last lock clear
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) fl_seen_ff <= 1'b0;
		else if (lock_bits_clear) fl_seen_ff <= 1'b0;
		else if (mem_we && mem_req.flash) fl_seen_ff <= 1'b1;
	end
	// ==========
	// Properties
	property p_we_busy; mem_we |-> !ready_busy_status; endproperty
	property p_we_mode; mem_we |-> prog_mode; endproperty
	property p_we_one; mem_we |-> mem_req.flash != mem_req.eeprom; endproperty
	property p_busy_cause; $fell(ready_busy_status) |-> wr_age_ff <= 4'h8; endproperty
	property p_busy_stand; $fell(ready_busy_status) |=> !ready_busy_status [*8]; endproperty
	property p_lock_pulse; lock_bits_clear |=> !lock_bits_clear; endproperty
	property p_lock_late; lock_bits_clear |-> fl_seen_ff && !mem_we; endproperty
	property p_mode_exit; $fell(hv_present) |-> ##[1:8] !prog_mode; endproperty
	a_we_busy: assert property (p_we_busy) else $error("write while ready");
	a_we_mode: assert property (p_we_mode) else $error("write outside mode");
	a_we_one: assert property (p_we_one) else $error("write target unclear");
	a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
	a_busy_stand: assert property (p_busy_stand) else $error("busy too short");
	a_lock_pulse: assert property (p_lock_pulse) else $error("lock clear not a pulse");
	a_lock_late: assert property (p_lock_late) else $error("lock cleared early");
	a_mode_exit: assert property (p_mode_exit) else $error("mode kept");
	c_busy: cover property ($fell(ready_busy_status));
	c_flash: cover property (mem_we && mem_req.flash);
	c_eeprom: cover property (mem_we && mem_req.eeprom);
endmodule
bind pppf_core pppf_chk pppf_chk_inst (.mclk(mclk), .resetn(resetn), .hv_present(hv_present),
	.write_strobe_n(write_strobe_n), .ready_busy_status(ready_busy_status),
	.prog_mode(prog_mode), .lock_bits_clear(lock_bits_clear), .mem_req(mem_req), .mem_we(mem_we));

/* File: sim/pppf_prog.sv */
// Model of the external programmer driving the port
`timescale 1ns/1ps
module pppf_prog (
	// Clock
	input  wire logic mclk,
	// Programming pins
	output logic      hv_present,
	output logic      action_select_hi,
	output logic      action_select_lo,
	output logic      byte_select_low,
	output logic      byte_select_second,
	output logic      page_latch_strobe,
	output logic      load_strobe,
	output logic      write_strobe_n,
	output logic [7:0] data_in
);
	import pppf_pkg::*;
	// Quiet pins at power up
	initial begin
		{hv_present, action_select_hi, action_select_lo, byte_select_low} = 4'h0;
		{byte_select_second, page_latch_strobe, load_strobe, write_strobe_n} = 4'h1;
		data_in = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	// Strobe held 40 cycles, one microsecond at 40 MHz
	task automatic strobe(input int which);
		tick(4);
		if (which == 0) load_strobe = 1'b1;
		else if (which == 1) page_latch_strobe = 1'b1;
		else write_strobe_n = 1'b0;
		tick(40);
		{load_strobe, page_latch_strobe, write_strobe_n} = 3'h1;
		data_in = ~data_in;
		tick(4);
	endtask
	task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] d);
		{action_select_hi, action_select_lo} = act;
		byte_select_low = bs;
		data_in = d;
		strobe(0);
	endtask
	task automatic latch();
		byte_select_low = 1'b1;
		strobe(1);
	endtask
	task automatic wr();
		strobe(2);
	endtask
	// Entry pattern held, then the long settle before commands
	task automatic enter();
		{action_select_hi, action_select_lo, page_latch_strobe, byte_select_second} = 4'h0;
		hv_present = 1'b1;
		tick(400);
		tick(12000);
	endtask
	task automatic leave();
		hv_present = 1'b0;
		tick(12);
	endtask
endmodule

/* File: sim/parallel_program_port_flow_tb.sv */
// Testbench for the parallel programming port
`timescale 1ns/1ps
module parallel_program_port_flow_tb;
	import pppf_pkg::*;
	logic       mclk, resetn, eeprom_preserve_fuse, hv_present, action_select_hi;
	logic       action_select_lo, byte_select_low, byte_select_second, page_latch_strobe;
	logic       load_strobe, write_strobe_n, ready_busy_status, prog_mode, mem_we, ee_seen;
	logic       lock_bits_clear, rec_clr;
	logic [7:0] data_in;
	logic [15:0] mem_wdata;
	logic [4:0] mem_word;
	pppf_req_t  mem_req;
	int         we_cnt, num_errors, samples_checked;
	logic [4:0] w_word [64];
	logic [15:0] w_data [64];
	pppf_req_t  w_req [64];
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	pppf_core pppf_core_inst (.mclk(mclk), .resetn(resetn), .hv_present(hv_present),
		.eeprom_preserve_fuse(eeprom_preserve_fuse), .action_select_hi(action_select_hi),
		.action_select_lo(action_select_lo), .byte_select_low(byte_select_low),
		.byte_select_second(byte_select_second), .page_latch_strobe(page_latch_strobe),
		.load_strobe(load_strobe), .write_strobe_n(write_strobe_n), .data_in(data_in),
		.ready_busy_status(ready_busy_status), .prog_mode(prog_mode),
		.lock_bits_clear(lock_bits_clear), .mem_req(mem_req), .mem_we(mem_we),
		.mem_wdata(mem_wdata), .mem_word(mem_word));
	pppf_prog pppf_prog_inst (.mclk(mclk), .hv_present(hv_present),
		.action_select_hi(action_select_hi), .action_select_lo(action_select_lo),
		.byte_select_low(byte_select_low), .byte_select_second(byte_select_second),
		.page_latch_strobe(page_latch_strobe), .load_strobe(load_strobe),
		.write_strobe_n(write_strobe_n), .data_in(data_in));
	// Count every array write cycle, log the first 64; rec_clr restarts the log
	always @(posedge mclk) begin
		if (rec_clr) begin
			we_cnt  <= 0;
			ee_seen <= 1'b0;
		end else if (mem_we === 1'b1) begin
			if (we_cnt < 64) begin
				w_word[we_cnt] <= mem_word;
				w_data[we_cnt] <= mem_wdata;
				w_req[we_cnt] <= mem_req;
			end
			we_cnt <= we_cnt + 1;
			if (mem_req.eeprom === 1'b1) ee_seen <= 1'b1;
		end
	end
	// ==========
	// Shared tasks
	task automatic results();
		if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rec_reset();
		rec_clr = 1'b1;
		pppf_prog_inst.tick(1);
		rec_clr = 1'b0;
	endtask
	task automatic wait_we(input int n);
		for (int k = 0; k < 4000 && we_cnt < n; k++) @(posedge mclk);
		#2;
		if (we_cnt < n) begin
			chk(16'(we_cnt), 16'(n));
			results();
		end
	endtask
	// Reset also aborts a long write, which keeps the run short
	task automatic abort();
		pppf_prog_inst.leave();
		chk(16'(prog_mode), 16'h0);
		resetn = 1'b0;
		pppf_prog_inst.tick(4);
		resetn = 1'b1;
		pppf_prog_inst.tick(4);
	endtask
	// ==========
	// Scenarios
	task automatic s_entry();
		pppf_prog_inst.enter();
		chk(16'(prog_mode), 16'h1);
	endtask
	task automatic s_refused();
		pppf_prog_inst.wr();
		chk(16'({ready_busy_status, prog_mode, 8'(we_cnt)}), 16'h200);
		pppf_prog_inst.byte_select_second = 1'b1;
		pppf_prog_inst.hv_present = 1'b1;
		pppf_prog_inst.tick(600);
		chk(16'(prog_mode), 16'h0);
		pppf_prog_inst.leave();
		s_entry();
		pppf_prog_inst.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
		pppf_prog_inst.load(ACT_DATA, 1'b0, 8'h5A);
		pppf_prog_inst.latch();
		for (int c = 0; c < 2; c++) begin
			pppf_prog_inst.load(ACT_CMD, 1'b0, (c == 0) ? CMD_NOP : 8'h40);
			pppf_prog_inst.wr();
			pppf_prog_inst.tick(20);
			chk(16'({ready_busy_status, 8'(we_cnt)}), 16'h100);
		end
	endtask
	task automatic s_flash();
		pppf_prog_inst.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
		for (int i = 0; i < 32; i++) begin
			pppf_prog_inst.load(ACT_ADDR, 1'b0, 8'hE0 + 8'(i));
			pppf_prog_inst.load(ACT_DATA, 1'b0, 8'(i));
			pppf_prog_inst.load(ACT_DATA, 1'b1, 8'hC0 | 8'(i));
			pppf_prog_inst.latch();
		end
		pppf_prog_inst.load(ACT_ADDR, 1'b1, 8'h02);
		pppf_prog_inst.wr();
		wait_we(32);
		pppf_prog_inst.tick(200);
		chk(16'({ready_busy_status, 8'(we_cnt)}), 16'h020);
		for (int i = 0; i < 32; i++) begin
			chk(16'({w_req[i].flash, w_req[i].page, 3'h0, w_word[i]}), 16'h9700 + 16'(i));
			chk(w_data[i], {8'hC0 | 8'(i), 8'(i)});
		end
	endtask
	task automatic s_eeprom();
		pppf_prog_inst.load(ACT_CMD, 1'b0, CMD_WR_EEP);
		pppf_prog_inst.load(ACT_ADDR, 1'b1, 8'h01);
		for (int k = 0; k < 4; k++) begin
			pppf_prog_inst.load(ACT_ADDR, 1'b0, 8'h44 + 8'(k));
			pppf_prog_inst.load(ACT_DATA, 1'b0, 8'h3C ^ 8'(k));
			pppf_prog_inst.latch();
		end
		pppf_prog_inst.byte_select_low = 1'b0;
		rec_reset();
		pppf_prog_inst.wr();
		wait_we(4);
		pppf_prog_inst.tick(20);
		chk(16'(we_cnt), 16'h4);
		for (int k = 0; k < 4; k++) begin
			chk(16'({w_req[k].eeprom, w_req[k].page, 3'h0, w_word[k]}), 16'hD100 + 16'(k));
			chk(16'(w_data[k][7:0]), 16'h3C ^ 16'(k));
		end
	endtask
	task automatic s_erase();
		eeprom_preserve_fuse = 1'b1;
		s_entry();
		pppf_prog_inst.load(ACT_CMD, 1'b0, CMD_ERASE);
		rec_reset();
		pppf_prog_inst.wr();
		wait_we(1);
		pppf_prog_inst.tick(500);
		chk(16'({ready_busy_status, w_req[0].flash, ee_seen, lock_bits_clear}), 16'h4);
	endtask
	initial begin
		resetn = 1'b0;
		eeprom_preserve_fuse = 1'b0;
		{num_errors, samples_checked} = '0;
		rec_clr = 1'b1;
		repeat (16) @(posedge mclk);
		#2;
		resetn = 1'b1;
		rec_clr = 1'b0;
		s_refused();
		rec_reset();
		s_flash();
		abort();
		s_entry();
		s_eeprom();
		abort();
		s_erase();
		results();
	end
endmodule
